//--- ipc_pkg.sv
// Package with the register map, field positions, reset values and carrier types.
package ipc_pkg;

  localparam int ADDR_W = 8;
  localparam int PC_W = 21;
  localparam int STACK_DEPTH = 31;
  localparam int SP_W = 5;

  // Register byte addresses on the AXI4-Lite port.
  localparam logic [ADDR_W-1:0] ADDR_PRI_ONE = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_PRI_TWO = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_PRI_THREE = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_RESET_CTRL = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_MAIN_CTRL = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_SECOND_CTRL = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_THIRD_CTRL = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_T0_LOW = 8'h1C;
  localparam logic [ADDR_W-1:0] ADDR_T0_HIGH = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_T0_CTRL = 8'h24;

  // Implemented bits and reset values.
  localparam logic [7:0] PRI_ONE_MASK = 8'h7F;
  localparam logic [7:0] PRI_TWO_MASK = 8'hCF;
  localparam logic [7:0] PRI_THREE_MASK = 8'h70;
  localparam logic [7:0] RESET_CTRL_WMASK = 8'hD3;
  localparam logic [7:0] RESET_CTRL_RST = 8'h5C;
  localparam logic [7:0] T0_CTRL_MASK = 8'hC0;
  localparam logic [7:0] T0_CTRL_RST = 8'h40;

  // Field positions.
  localparam int RC_PRIO_EN = 7;
  localparam int RC_WDT_TO = 3;
  localparam int RC_PWR_DN = 2;
  localparam int MC_GIE = 7;
  localparam int MC_PERIPHERAL_IRQ_GLOBAL_ENABLE = 6;
  localparam int MC_T0_EN = 5;
  localparam int MC_X0_EN = 4;
  localparam int MC_RB_EN = 3;
  localparam int MC_T0_FLAG = 2;
  localparam int MC_X0_FLAG = 1;
  localparam int MC_RB_FLAG = 0;
  localparam int SC_EDGE_LSB = 3;
  localparam int SC_T0_PRI = 2;
  localparam int SC_X3_PRI = 1;
  localparam int SC_RB_PRI = 0;
  localparam int TC_X2_PRI = 7;
  localparam int TC_X1_PRI = 6;
  localparam int TC_EN_LSB = 3;
  localparam int TC_FLAG_LSB = 0;
  localparam int T0C_ON = 7;
  localparam int T0C_EIGHT = 6;
  localparam int LCD_SRC = 22;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } ipc_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ipc_axi_rsp_t;

  typedef struct packed {
    logic irq_ack;
    logic ret_pop;
    logic [PC_W-1:0] return_pc;
    logic [7:0] working_register;
    logic [7:0] status;
    logic [7:0] bank_select_register;
    logic sleeping;
    logic wdt_timeout;
  } ipc_core_in_t;

  typedef struct packed {
    logic high_req;
    logic low_req;
    logic wake;
    logic wake_vector;
    logic [PC_W-1:0] stack_top;
    logic [SP_W-1:0] stack_ptr;
    logic [7:0] shadow_working;
    logic [7:0] shadow_status;
    logic [7:0] shadow_bank;
  } ipc_core_out_t;

  typedef struct packed {
    logic [23:0] flag;
    logic [23:0] enable;
  } ipc_periph_t;

endpackage

//--- ipc_ctrl.sv
// Interrupt priority controller with external pins, timer zero, port change and context save.
//
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps

module ipc_ctrl
  import ipc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire ipc_axi_req_t axi_req,
  output ipc_axi_rsp_t axi_rsp,
  input wire ipc_core_in_t core_in,
  output ipc_core_out_t core_out,
  input wire ipc_periph_t periph,
  input wire logic [7:0] port_b_pins,
  input wire logic t0_tick,
  input wire logic lcd_type_b_multiplex
);

  typedef struct packed {
    logic aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [7:0] w_data;
    logic w_lane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [7:0] pri_one;
    logic [7:0] pri_two;
    logic [7:0] pri_three;
    logic [7:0] reset_ctrl;
    logic [7:0] main_ctrl;
    logic [7:0] second_ctrl;
    logic [7:0] third_ctrl;
    logic [15:0] t0_count;
    logic [7:0] t0_ctrl;
    logic [7:0] pins_prev;
    logic sleep_prev;
    logic [3:0] en_at_sleep;
    logic high_req;
    logic low_req;
    logic wake;
    logic wake_vector;
    logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
    logic [SP_W-1:0] sp;
    logic [7:0] sh_working;
    logic [7:0] sh_status;
    logic [7:0] sh_bank;
  } ipc_state_t;

  ipc_state_t s;
  ipc_state_t next_s;

  ////////////////////////////////////////////////////////////////////////////
  // Register read decode.

  function automatic logic [8:0] read_reg(input ipc_state_t st, input logic [ADDR_W-1:0] a);
    logic [8:0] r;
    r = {1'b1, 8'h00};
    unique case (a)
      ADDR_PRI_ONE: r[7:0] = st.pri_one & PRI_ONE_MASK;
      ADDR_PRI_TWO: r[7:0] = st.pri_two & PRI_TWO_MASK;
      ADDR_PRI_THREE: r[7:0] = st.pri_three & PRI_THREE_MASK;
      ADDR_RESET_CTRL: r[7:0] = st.reset_ctrl;
      ADDR_MAIN_CTRL: r[7:0] = st.main_ctrl;
      ADDR_SECOND_CTRL: r[7:0] = st.second_ctrl;
      ADDR_THIRD_CTRL: r[7:0] = st.third_ctrl;
      ADDR_T0_LOW: r[7:0] = st.t0_count[7:0];
      ADDR_T0_HIGH: r[7:0] = st.t0_count[15:8];
      ADDR_T0_CTRL: r[7:0] = st.t0_ctrl;
      default: r[8] = 1'b0;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  logic do_write;
  logic [8:0] wr_hit;
  logic [8:0] rd_val;
  logic [7:0] rise;
  logic [7:0] fall;
  logic [3:0] ext_edge;
  logic [3:0] edge_sel;
  logic rb_change;
  logic t0_ovf;
  logic [16:0] t0_sum;
  logic [5:0] src_act;
  logic [5:0] src_pri;
  logic [23:0] per_act;
  logic [23:0] per_pri;
  logic any_high;
  logic any_low;
  logic any_core;
  logic any_per;
  logic sleep_entry;

  always_comb begin
    next_s = s;
    do_write = s.aw_got && s.w_got && !s.bvalid;
    wr_hit = read_reg(s, s.aw_addr);
    rd_val = read_reg(s, axi_req.araddr);

    // AXI channel bookkeeping; address and data may arrive in either order.
    if (axi_req.awvalid && !s.aw_got) begin
      next_s.aw_got = 1'b1;
      next_s.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !s.w_got) begin
      next_s.w_got = 1'b1;
      next_s.w_data = axi_req.wdata[7:0];
      next_s.w_lane = axi_req.wstrb[0];
    end
    if (s.bvalid && axi_req.bready) begin
      next_s.bvalid = 1'b0;
    end
    if (do_write) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = wr_hit[8] ? RESP_OKAY : RESP_SLVERR;
    end
    if (s.rvalid && axi_req.rready) begin
      next_s.rvalid = 1'b0;
    end
    if (axi_req.arvalid && !s.rvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_val[7:0];
      next_s.rresp = rd_val[8] ? RESP_OKAY : RESP_SLVERR;
    end

    // Software writes; only byte lane 0 carries register data.
    if (do_write && s.w_lane) begin
      unique case (s.aw_addr)
        ADDR_PRI_ONE: next_s.pri_one = s.w_data & PRI_ONE_MASK;
        ADDR_PRI_TWO: next_s.pri_two = s.w_data & PRI_TWO_MASK;
        ADDR_PRI_THREE: next_s.pri_three = s.w_data & PRI_THREE_MASK;
        ADDR_RESET_CTRL: begin
          next_s.reset_ctrl = (s.w_data & RESET_CTRL_WMASK) |
                              (s.reset_ctrl & ~RESET_CTRL_WMASK);
        end
        ADDR_MAIN_CTRL: next_s.main_ctrl = s.w_data;
        ADDR_SECOND_CTRL: next_s.second_ctrl = s.w_data;
        ADDR_THIRD_CTRL: next_s.third_ctrl = s.w_data;
        ADDR_T0_LOW: next_s.t0_count[7:0] = s.w_data;
        ADDR_T0_HIGH: next_s.t0_count[15:8] = s.w_data;
        ADDR_T0_CTRL: next_s.t0_ctrl = s.w_data & T0_CTRL_MASK;
        default: next_s.t0_ctrl = s.t0_ctrl;
      endcase
    end

    // Pin events: each sample is compared with the one taken a cycle earlier.
    next_s.pins_prev = port_b_pins;
    rise = port_b_pins & ~s.pins_prev;
    fall = ~port_b_pins & s.pins_prev;
    edge_sel = s.second_ctrl[SC_EDGE_LSB +: 4];
    ext_edge = (edge_sel & rise[3:0]) | (~edge_sel & fall[3:0]);
    rb_change = |(rise[7:4] | fall[7:4]);

    // Timer zero counts on the tick enable.
    t0_sum = {1'b0, next_s.t0_count} + 17'h00001;
    t0_ovf = 1'b0;
    if (s.t0_ctrl[T0C_ON] && t0_tick) begin
      if (s.t0_ctrl[T0C_EIGHT]) begin
        t0_ovf = (next_s.t0_count[7:0] == 8'hFF);
        next_s.t0_count[7:0] = t0_sum[7:0];
      end else begin
        t0_ovf = t0_sum[16];
        next_s.t0_count = t0_sum[15:0];
      end
    end

    // Hardware sets a flag after the software write, so a set in the same
    // cycle as a clear is kept. Nothing here ever clears these flags.
    next_s.main_ctrl[MC_X0_FLAG] = next_s.main_ctrl[MC_X0_FLAG] | ext_edge[0];
    next_s.third_ctrl[TC_FLAG_LSB +: 3] = next_s.third_ctrl[TC_FLAG_LSB +: 3] |
                                          ext_edge[3:1];
    next_s.main_ctrl[MC_RB_FLAG] = next_s.main_ctrl[MC_RB_FLAG] | rb_change;
    next_s.main_ctrl[MC_T0_FLAG] = next_s.main_ctrl[MC_T0_FLAG] | t0_ovf;

    // Core-side sources in order timer, pin0, pin1, pin2, pin3, port change.
    src_act[0] = s.main_ctrl[MC_T0_FLAG] && s.main_ctrl[MC_T0_EN];
    src_act[1] = s.main_ctrl[MC_X0_FLAG] && s.main_ctrl[MC_X0_EN];
    src_act[4:2] = s.third_ctrl[TC_FLAG_LSB +: 3] & s.third_ctrl[TC_EN_LSB +: 3];
    src_act[5] = s.main_ctrl[MC_RB_FLAG] && s.main_ctrl[MC_RB_EN];
    src_pri[0] = s.second_ctrl[SC_T0_PRI];
    src_pri[1] = 1'b1;
    src_pri[2] = s.third_ctrl[TC_X1_PRI];
    src_pri[3] = s.third_ctrl[TC_X2_PRI];
    src_pri[4] = s.second_ctrl[SC_X3_PRI];
    src_pri[5] = s.second_ctrl[SC_RB_PRI];

    // The display source is dropped unless its waveform makes it meaningful.
    per_act = periph.flag & periph.enable;
    per_act[LCD_SRC] = per_act[LCD_SRC] && lcd_type_b_multiplex;
    per_pri = {s.pri_three & PRI_THREE_MASK, s.pri_two & PRI_TWO_MASK,
               s.pri_one & PRI_ONE_MASK};

    any_core = |src_act;
    any_per = |per_act;
    any_high = |(src_act & src_pri) || |(per_act & per_pri);
    any_low = |(src_act & ~src_pri) || |(per_act & ~per_pri);
    if (s.reset_ctrl[RC_PRIO_EN]) begin
      next_s.high_req = s.main_ctrl[MC_GIE] && any_high;
      next_s.low_req = s.main_ctrl[MC_GIE] && s.main_ctrl[MC_PERIPHERAL_IRQ_GLOBAL_ENABLE] && any_low;
    end else begin
      // Legacy single level; everything goes out on the high request line.
      next_s.high_req = s.main_ctrl[MC_GIE] &&
                        (any_core || (s.main_ctrl[MC_PERIPHERAL_IRQ_GLOBAL_ENABLE] && any_per));
      next_s.low_req = 1'b0;
    end

    // Sleep entry freezes the pin enables that may wake the core.
    sleep_entry = core_in.sleeping && !s.sleep_prev;
    next_s.sleep_prev = core_in.sleeping;
    if (sleep_entry) begin
      next_s.en_at_sleep = {s.third_ctrl[TC_EN_LSB +: 3], s.main_ctrl[MC_X0_EN]};
      next_s.reset_ctrl[RC_PWR_DN] = 1'b0;
    end
    if (core_in.wdt_timeout) begin
      next_s.reset_ctrl[RC_WDT_TO] = 1'b0;
    end
    next_s.wake = core_in.sleeping && !sleep_entry &&
                  |(ext_edge & s.en_at_sleep);
    next_s.wake_vector = next_s.wake && s.main_ctrl[MC_GIE];

    // Interrupt entry: a full stack refuses the push instead of wrapping.
    if (core_in.irq_ack) begin
      if (s.sp < SP_W'(STACK_DEPTH)) begin
        next_s.stack[s.sp] = core_in.return_pc;
        next_s.sp = s.sp + 5'h01;
      end
      next_s.sh_working = core_in.working_register;
      next_s.sh_status = core_in.status;
      next_s.sh_bank = core_in.bank_select_register;
    end else if (core_in.ret_pop && s.sp != 5'h00) begin
      next_s.sp = s.sp - 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s <= '0;
      s.pri_one <= PRI_ONE_MASK;
      s.pri_two <= PRI_TWO_MASK;
      s.pri_three <= PRI_THREE_MASK;
      s.reset_ctrl <= RESET_CTRL_RST;
      s.t0_ctrl <= T0_CTRL_RST;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  always_comb begin
    axi_rsp.awready = !s.aw_got;
    axi_rsp.wready = !s.w_got;
    axi_rsp.bvalid = s.bvalid;
    axi_rsp.bresp = s.bresp;
    axi_rsp.arready = !s.rvalid;
    axi_rsp.rvalid = s.rvalid;
    axi_rsp.rdata = {24'h000000, s.rdata};
    axi_rsp.rresp = s.rresp;
    core_out.high_req = s.high_req;
    core_out.low_req = s.low_req;
    core_out.wake = s.wake;
    core_out.wake_vector = s.wake_vector;
    core_out.stack_top = (s.sp == 5'h00) ? 21'h000000 : s.stack[s.sp - 5'h01];
    core_out.stack_ptr = s.sp;
    core_out.shadow_working = s.sh_working;
    core_out.shadow_status = s.sh_status;
    core_out.shadow_bank = s.sh_bank;
  end

endmodule

//--- ipc_ctrl_checker.sv
// Concurrent checks on the controller's bus, stack, shadow and wake ports.
`timescale 1ns/1ps
module ipc_ctrl_checker
  import ipc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire ipc_axi_req_t axi_req,
  input wire ipc_axi_rsp_t axi_rsp,
  input wire ipc_core_in_t core_in,
  input wire ipc_core_out_t core_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////
  a_read_upper: assert property (
    axi_rsp.rvalid |-> axi_rsp.rdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_read_hold: assert property (
    axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read answer dropped early");
  a_bad_read: assert property (
    axi_req.arvalid && axi_rsp.arready && axi_req.araddr > ADDR_T0_CTRL
    |=> axi_rsp.rresp == RESP_SLVERR && axi_rsp.rdata == 32'h0)
    else $error("unmapped read not refused");
  a_write_order: assert property (
    $rose(axi_rsp.bvalid) |-> $past(!axi_rsp.awready && !axi_rsp.wready))
    else $error("write answer before both channels taken");
  a_write_hold: assert property (
    axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write answer dropped early");
  a_stack_push: assert property (
    core_in.irq_ack && core_out.stack_ptr != 5'h1F
    |=> core_out.stack_ptr == $past(core_out.stack_ptr) + 5'h01
    && core_out.stack_top == $past(core_in.return_pc))
    else $error("entry did not push return address");
  a_stack_pop: assert property (
    core_in.ret_pop && !core_in.irq_ack && core_out.stack_ptr != 5'h00
    |=> core_out.stack_ptr == $past(core_out.stack_ptr) - 5'h01)
    else $error("return did not pop stack");
  a_shadow_copy: assert property (
    core_in.irq_ack |=> core_out.shadow_working == $past(core_in.working_register)
    && core_out.shadow_status == $past(core_in.status)
    && core_out.shadow_bank == $past(core_in.bank_select_register))
    else $error("entry did not copy context");
  a_wake_vector: assert property (
    core_out.wake_vector |-> core_out.wake && $past(core_in.sleeping))
    else $error("vector without wake");
  c_write: cover property (axi_rsp.bvalid && axi_req.bready);
  c_push: cover property (core_in.irq_ack);
  c_wake: cover property (core_out.wake_vector);
  c_low: cover property (core_out.low_req);
endmodule

bind ipc_ctrl ipc_ctrl_checker i_ipc_ctrl_checker (.ref_clk(ref_clk), .reset(reset),
  .axi_req(axi_req), .axi_rsp(axi_rsp), .core_in(core_in), .core_out(core_out));

//--- ipc_core_model.sv
// Behavioural core that acknowledges requests and supplies context to save.
`timescale 1ns/1ps
module ipc_core_model
  import ipc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire ipc_core_out_t core_out,
  input wire logic ack_en,
  input wire logic pop,
  input wire logic sleep,
  input wire logic tmo,
  output ipc_core_in_t core_in
);
  logic ack;
  logic acked;
  logic [PC_W-1:0] pc;
  // Return address, working and status move every cycle (bank only every few), so a stale copy of them cannot pass for a fresh one.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ack <= 1'b0;
      acked <= 1'b0;
      pc <= '0;
    end else begin
      pc <= pc + 21'h1B3;
      ack <= ack_en && !acked && !ack && (core_out.high_req || core_out.low_req);
      acked <= ack_en && (acked || ack);
    end
  end
  assign core_in = '{irq_ack: ack, ret_pop: pop, return_pc: pc, working_register: pc[7:0],
    status: pc[15:8], bank_select_register: pc[20:13], sleeping: sleep, wdt_timeout: tmo};
endmodule

//--- interrupt_priority_and_external_sources_tb.sv
// Self-checking bench for the interrupt priority controller.
`timescale 1ns/1ps
module interrupt_priority_and_external_sources_tb;
  import ipc_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  ipc_axi_req_t rq = '0;
  ipc_axi_rsp_t rs;
  ipc_core_in_t ci;
  ipc_core_out_t co;
  ipc_periph_t pe = '0;
  logic [7:0] pb = 8'h00;
  logic tick = 1'b0;
  logic lcd = 1'b0;
  logic ack_en = 1'b0;
  logic pop = 1'b0;
  logic sleep = 1'b0;
  logic tmo = 1'b0;
  logic [31:0] s = 32'h00011C3D;
  logic [31:0] d;
  logic [31:0] v;
  logic [7:0] a;
  logic [1:0] r;
  logic w;
  logic wv;
  int bad_count = 0;
  int comparisons = 0;
  always #20 ref_clk = ~ref_clk;
  ipc_ctrl i_ipc_ctrl (.ref_clk(ref_clk), .reset(reset), .axi_req(rq), .axi_rsp(rs),
    .core_in(ci), .core_out(co), .periph(pe), .port_b_pins(pb), .t0_tick(tick),
    .lcd_type_b_multiplex(lcd));
  ipc_core_model i_ipc_core_model (.ref_clk(ref_clk), .reset(reset), .core_out(co),
    .ack_en(ack_en), .pop(pop), .sleep(sleep), .tmo(tmo), .core_in(ci));
  ////////////////////////////////
  task results;
    if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task hang;
    bad_count++;
    results;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function logic [31:0] xs();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  function logic [31:0] exp_pri(input logic [7:0] ad, input logic [31:0] val);
    return {24'h0, val[7:0] & (ad == 8'h00 ? 8'h7F : ad == 8'h04 ? 8'hCF : 8'h70)};
  endfunction
  task cy(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Ready is sampled at the falling edge, where nothing moves until the next rising edge.
  task wr(input logic [7:0] ad, input logic [31:0] val);
    int n;
    logic ga;
    logic gw;
    logic ra;
    logic rw;
    @(posedge ref_clk);
    rq.awaddr <= ad;
    rq.wdata <= val;
    rq.wstrb <= 4'hF;
    rq.awvalid <= 1'b1;
    rq.wvalid <= 1'b1;
    rq.bready <= 1'b1;
    ga = 1'b0;
    gw = 1'b0;
    for (n = 0; n < 40 && !(ga && gw); n++) begin
      @(negedge ref_clk);
      ra = rs.awready === 1'b1 && !ga;
      rw = rs.wready === 1'b1 && !gw;
      @(posedge ref_clk);
      if (ra) rq.awvalid <= 1'b0;
      if (rw) rq.wvalid <= 1'b0;
      ga = ga | ra;
      gw = gw | rw;
    end
    if (!(ga && gw)) hang;
    for (n = 0; n < 40; n++) begin
      @(negedge ref_clk);
      if (rs.bvalid === 1'b1) break;
    end
    if (n == 40) hang;
    r = rs.bresp;
    @(posedge ref_clk);
    rq.bready <= 1'b0;
  endtask
  task rd(input logic [7:0] ad);
    int n;
    @(posedge ref_clk);
    rq.araddr <= ad;
    rq.arvalid <= 1'b1;
    rq.rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge ref_clk);
      if (rs.arready === 1'b1) break;
    end
    if (n == 40) hang;
    @(posedge ref_clk);
    rq.arvalid <= 1'b0;
    for (n = 0; n < 40; n++) begin
      @(negedge ref_clk);
      if (rs.rvalid === 1'b1) break;
    end
    if (n == 40) hang;
    d = rs.rdata;
    r = rs.rresp;
    @(posedge ref_clk);
    rq.rready <= 1'b0;
  endtask
  task rdc(input logic [7:0] ad, input logic [31:0] exp);
    rd(ad);
    chk($sformatf("rdata at %h", ad), d, exp);
  endtask
  task rqc(input logic h, input logic l);
    cy(3);
    @(negedge ref_clk);
    chk("high_req", co.high_req, h);
    chk("low_req", co.low_req, l);
    @(posedge ref_clk);
  endtask
  task tk;
    @(posedge ref_clk);
    tick <= 1'b1;
    @(posedge ref_clk);
    tick <= 1'b0;
  endtask
  ////////////////////////////////
  initial begin
    cy(10);
    reset <= 1'b0;
    rdc(ADDR_PRI_ONE, 32'h7F);
    rdc(ADDR_PRI_TWO, 32'hCF);
    rdc(ADDR_PRI_THREE, 32'h70);
    rdc(ADDR_RESET_CTRL, 32'h5C);
    rdc(ADDR_T0_CTRL, 32'h40);
    rd(8'h40);
    chk("rresp", r, RESP_SLVERR);
    wr(8'h40, 32'hFF);
    chk("bresp", r, RESP_SLVERR);
    for (int i = 0; i < 9; i++) begin
      a = 8'(4 * (i % 3));
      v = xs();
      wr(a, v);
      rdc(a, exp_pri(a, v));
    end
    // Read-only cause flags keep their value when software writes ones.
    wr(ADDR_RESET_CTRL, 32'hFF);
    rdc(ADDR_RESET_CTRL, 32'hDF);
    @(posedge ref_clk) tmo <= 1'b1;
    @(posedge ref_clk) tmo <= 1'b0;
    rdc(ADDR_RESET_CTRL, 32'hD7);
    wr(ADDR_MAIN_CTRL, 32'hC0);
    wr(ADDR_PRI_ONE, 32'h01);
    pe <= '{flag: 24'h1, enable: 24'h1};
    rqc(1'b1, 1'b0);
    wr(ADDR_PRI_ONE, 32'h00);
    rqc(1'b0, 1'b1);
    wr(ADDR_RESET_CTRL, 32'h00);
    rqc(1'b1, 1'b0);
    wr(ADDR_MAIN_CTRL, 32'h80);
    rqc(1'b0, 1'b0);
    wr(ADDR_MAIN_CTRL, 32'hC0);
    pe <= '{flag: 24'h400000, enable: 24'h400000};
    rqc(1'b0, 1'b0);
    lcd <= 1'b1;
    rqc(1'b1, 1'b0);
    pe <= '0;
    for (int e = 0; e < 2; e++) begin
      pb[0] <= ~e[0];
      wr(ADDR_SECOND_CTRL, {28'h0, e[0], 3'h0});
      wr(ADDR_MAIN_CTRL, 32'h90);
      pb[0] <= e[0];
      cy(3);
      rdc(ADDR_MAIN_CTRL, 32'h92);
      rqc(1'b1, 1'b0);
      wr(ADDR_MAIN_CTRL, 32'h80);
      pb[0] <= ~e[0];
      cy(3);
      rdc(ADDR_MAIN_CTRL, 32'h80);
      pb[0] <= e[0];
      rqc(1'b0, 1'b0);
    end
    wr(ADDR_RESET_CTRL, 32'h80);
    wr(ADDR_MAIN_CTRL, 32'hC0);
    wr(ADDR_SECOND_CTRL, 32'h18);
    wr(ADDR_THIRD_CTRL, 32'h08);
    pb[1] <= 1'b1;
    rqc(1'b0, 1'b1);
    wr(ADDR_THIRD_CTRL, 32'h49);
    rqc(1'b1, 1'b0);
    wr(ADDR_THIRD_CTRL, 32'h00);
    for (int g = 1; g >= 0; g--) begin
      sleep <= 1'b0;
      wr(ADDR_MAIN_CTRL, {24'h0, g[0], 7'h50});
      pb[0] <= 1'b0;
      sleep <= 1'b1;
      cy(2);
      pb[0] <= 1'b1;
      w = 1'b0;
      wv = 1'b0;
      repeat (6) begin
        @(negedge ref_clk);
        w = w | co.wake;
        wv = wv | co.wake_vector;
      end
      chk("wake", w, 1'b1);
      chk("wake_vector", wv, g[0]);
      @(posedge ref_clk);
    end
    sleep <= 1'b0;
    wr(ADDR_MAIN_CTRL, 32'h92);
    ack_en <= 1'b1;
    cy(4);
    @(negedge ref_clk);
    chk("stack_ptr", co.stack_ptr, 1);
    cy(1);
    ack_en <= 1'b0;
    pop <= 1'b1;
    cy(1);
    pop <= 1'b0;
    @(negedge ref_clk);
    chk("stack_ptr", co.stack_ptr, 0);
    wr(ADDR_MAIN_CTRL, 32'hE0);
    wr(ADDR_T0_CTRL, 32'hC0);
    wr(ADDR_T0_LOW, 32'hFF);
    tk;
    rdc(ADDR_MAIN_CTRL, 32'hE4);
    rqc(1'b0, 1'b1);
    wr(ADDR_SECOND_CTRL, 32'h1C);
    rqc(1'b1, 1'b0);
    wr(ADDR_MAIN_CTRL, 32'hE0);
    wr(ADDR_T0_CTRL, 32'h80);
    wr(ADDR_T0_HIGH, 32'hFF);
    wr(ADDR_T0_LOW, 32'hFF);
    tk;
    rdc(ADDR_MAIN_CTRL, 32'hE4);
    wr(ADDR_SECOND_CTRL, 32'h18);
    wr(ADDR_MAIN_CTRL, 32'hC8);
    pb[5] <= 1'b1;
    cy(3);
    rdc(ADDR_MAIN_CTRL, 32'hC9);
    rqc(1'b0, 1'b1);
    results;
  end
endmodule
